// file: shared/spi_access_pkg.sv
package spi_access_pkg;

    // ----------------------------------------------------------------
    // datagram layout
    // ----------------------------------------------------------------
    localparam int FRAME_BITS   = 40;
    localparam int DATA_BITS    = 32;
    localparam int ADDR_BITS    = 7;
    localparam int STATUS_BITS  = 8;
    localparam int DIR_BIT_POS  = 39;
    localparam int ADDR_MSB_POS = 38;
    localparam int ADDR_LSB_POS = 32;
    localparam int CNT_BITS     = 6;

    // saturating bit count of a frame; 40 or more means a full datagram
    localparam logic [CNT_BITS-1:0] CNT_FULL = 6'h28;
    localparam logic [CNT_BITS-1:0] CNT_ONE  = 6'h01;

    // ----------------------------------------------------------------
    // status byte field positions and reset value
    // ----------------------------------------------------------------
    localparam int STAT_RESET_POS = 0;
    localparam int STAT_DRV1_POS  = 1;
    localparam int STAT_DRV2_POS  = 2;
    localparam logic [STATUS_BITS-1:0] STATUS_RESET = 8'h00;
    localparam logic [DATA_BITS-1:0]   DATA_RESET   = 32'h0000_0000;

    // ----------------------------------------------------------------
    // timing: input filter
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int FILTER_MIN_NS = 20;
    // least time, rounded up to whole cycles
    localparam int FILTER_CYCLES =
        (FILTER_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int FILTER_CH = 2;
    localparam int CH_SELECT = 0;
    localparam int CH_ENABLE = 1;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                 write_not_read_bit;
        logic [ADDR_BITS-1:0] addr;
        logic [DATA_BITS-1:0] data;
    } command_t;

    typedef struct packed {
        logic [STATUS_BITS-1:0] status;
        logic [DATA_BITS-1:0]   data;
    } reply_t;

    typedef struct packed {
        logic drv2_error;
        logic drv1_error;
        logic reset_flag;
    } status_flags_t;

endpackage : spi_access_pkg

// file: verilog/input_deglitch.sv
`timescale 1ns/1ns
`default_nettype none

// two-flop synchroniser followed by a run-length filter per channel
module input_deglitch
    import spi_access_pkg::*;
(
    // clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 rst_in,
    // raw pins and filtered levels
    input  wire logic [FILTER_CH-1:0] raw_in,
    output logic      [FILTER_CH-1:0] level_out
);

    genvar ch;
    generate
        for (ch = 0; ch < FILTER_CH; ch++) begin : g_ch
            logic       meta_q;
            logic       sync_q;
            logic [3:0] run_q;
            logic       level_q;

            // inputs idle high; reset to the inactive level
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    meta_q <= 1'b1;
                    sync_q <= 1'b1;
                end else begin
                    meta_q <= raw_in[ch];
                    sync_q <= meta_q;
                end
            end

            // a level must hold this many samples before it is believed,
            // so a pulse shorter than FILTER_CYCLES - 1 clock periods never moves the output
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    run_q   <= 4'h0;
                    level_q <= 1'b1;
                end else if (sync_q == level_q) begin
                    run_q <= 4'h0;
                end else if (run_q == 4'(FILTER_CYCLES - 1)) begin
                    run_q   <= 4'h0;
                    level_q <= sync_q;
                end else begin
                    run_q <= run_q + 4'h1;
                end
            end

            assign level_out[ch] = level_q;
        end
    endgenerate

endmodule : input_deglitch

`default_nettype wire

// file: verilog/spi_link_shifter.sv
`timescale 1ns/1ns
`default_nettype none

// bus-clock side: 40-bit shift register, mode 3 timing
module spi_link_shifter
    import spi_access_pkg::*;
(
    // link pins
    input  wire logic                  sck_in,
    input  wire logic                  chip_select_n_in,
    input  wire logic                  sdi_in,
    // reply word, held stable by the system side while a frame runs
    input  wire logic [FRAME_BITS-1:0] reply_in,
    // received frame, stable once the select has gone high
    output logic      [FRAME_BITS-1:0] frame_out,
    output logic      [CNT_BITS-1:0]   count_out,
    output logic                       sdo_out
);

    logic [FRAME_BITS-1:0] shift_q;
    logic [CNT_BITS-1:0]   count_q;
    logic                  first_q;
    logic                  sdo_fall_q;

    // ----------------------------------------------------------------
    // frame start marker
    // ----------------------------------------------------------------
    // preset while the select is high; the select only presets this flag and does not stop shifting or counting
    always_ff @(posedge sck_in or posedge chip_select_n_in) begin
        if (chip_select_n_in) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // shift register, sampled on the rising edge, msb first
    // ----------------------------------------------------------------
    // the reply is loaded on the first rising edge, so every bit shifted in
    // leaves on the output exactly one frame length later
    always_ff @(posedge sck_in) begin
        if (first_q) begin
            shift_q <= {reply_in[FRAME_BITS-2:0], sdi_in};
        end else begin
            shift_q <= {shift_q[FRAME_BITS-2:0], sdi_in};
        end
    end

    // count is not cleared by the select, so the system side can still
    // read it after the frame has ended
    always_ff @(posedge sck_in) begin
        if (first_q) begin
            count_q <= CNT_ONE;
        end else if (count_q != CNT_FULL) begin
            count_q <= count_q + CNT_ONE;
        end
    end

    // ----------------------------------------------------------------
    // output, changed after the falling edge
    // ----------------------------------------------------------------
    always_ff @(negedge sck_in) begin
        sdo_fall_q <= shift_q[FRAME_BITS-1];
    end

    // before the first falling edge the reply msb has to be on the pin
    assign sdo_out   = first_q ? reply_in[FRAME_BITS-1] : sdo_fall_q;
    assign frame_out = shift_q;
    assign count_out = count_q;

endmodule : spi_link_shifter

`default_nettype wire

// file: verilog/spi_register_access_slave.sv
`timescale 1ns/1ns
`default_nettype none

module spi_register_access_slave
    import spi_access_pkg::*;
(
    // system clock and reset
    input  wire logic                 CLK_IN,
    input  wire logic                 RST_IN,
    // serial link
    input  wire logic                 SCK_IN,
    input  wire logic                 CHIP_SELECT_N_IN,
    input  wire logic                 SDI_IN,
    output logic                      SDO_OUT,
    output logic                      SDO_OE_OUT,
    // driver enable pin and its filtered level
    input  wire logic                 DRIVER_ENABLE_N_IN,
    output logic                      DRIVER_ENABLE_N_OUT,
    // register file access
    output logic                      REG_WRITE_OUT,
    output logic                      REG_READ_OUT,
    output logic      [ADDR_BITS-1:0] REG_ADDR_OUT,
    output logic      [DATA_BITS-1:0] REG_WDATA_OUT,
    input  wire logic [DATA_BITS-1:0] REG_RDATA_IN,
    // flags of the global status register
    input  wire status_flags_t        STATUS_FLAGS_IN,
    // diagnostics
    output logic                      SHORT_FRAME_OUT
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DECODE,
        ST_READ_CAPTURE
    } state_t;

    state_t                state_q;
    state_t                state_d;

    logic [FILTER_CH-1:0]  raw_pins;
    logic [FILTER_CH-1:0]  filtered;
    logic                  select_n_lvl;
    logic                  select_n_prev_q;
    logic                  select_rise;

    logic [FRAME_BITS-1:0] frame_word;
    logic [CNT_BITS-1:0]   frame_count;
    logic                  link_sdo;

    command_t              command_q;
    reply_t                reply_q;
    logic [STATUS_BITS-1:0] status_byte;

    logic                  sdo_meta_q;
    logic                  sdo_q;
    logic                  oe_meta_q;
    logic                  sdo_oe_q;
    logic                  enable_n_q;
    logic                  write_q;
    logic                  read_q;
    logic [ADDR_BITS-1:0]  addr_q;
    logic [DATA_BITS-1:0]  wdata_q;
    logic                  short_q;

    // ----------------------------------------------------------------
    // input filtering and synchronisation
    // ----------------------------------------------------------------
    assign raw_pins[CH_SELECT] = CHIP_SELECT_N_IN;
    assign raw_pins[CH_ENABLE] = DRIVER_ENABLE_N_IN;

    input_deglitch input_deglitch_i (
        .clk_in    (CLK_IN),
        .rst_in    (RST_IN),
        .raw_in    (raw_pins),
        .level_out (filtered)
    );

    assign select_n_lvl = filtered[CH_SELECT];

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            enable_n_q <= 1'b1;
        end else begin
            enable_n_q <= filtered[CH_ENABLE];
        end
    end

    // select edge seen by sampling on the system clock
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            select_n_prev_q <= 1'b1;
        end else begin
            select_n_prev_q <= select_n_lvl;
        end
    end

    assign select_rise = select_n_lvl & ~select_n_prev_q;

    // ----------------------------------------------------------------
    // link side
    // ----------------------------------------------------------------
    // the reply word crosses as a quasi-static word: it is only rewritten
    // while the filtered select is high, and the frame word is only read
    // after the select rise has passed the filter, when the bus clock
    // has stopped; a master breaking the high-time limit breaks this
    spi_link_shifter spi_link_shifter_i (
        .sck_in           (SCK_IN),
        .chip_select_n_in (CHIP_SELECT_N_IN),
        .sdi_in           (SDI_IN),
        .reply_in         (reply_q),
        .frame_out        (frame_word),
        .count_out        (frame_count),
        .sdo_out          (link_sdo)
    );

    // pin output is released outside frames so slaves can share the line;
    // the raw select passes two flops first, so the enable never goes metastable
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            oe_meta_q <= 1'b1;
            sdo_oe_q  <= 1'b0;
        end else begin
            oe_meta_q <= CHIP_SELECT_N_IN;
            sdo_oe_q  <= ~oe_meta_q;
        end
    end

    // the link output changes on the bus clock; it is retimed through two
    // flops so the pin comes from a clean flop. this adds up to two system
    // cycles of delay, which the bus-clock low-time limit leaves room for
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            sdo_meta_q <= 1'b1;
            sdo_q      <= 1'b1;
        end else begin
            sdo_meta_q <= link_sdo;
            sdo_q      <= sdo_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // command capture on select rise
    // ----------------------------------------------------------------
    // the shift register only ever holds the newest 40 bits, so longer
    // daisy-chain frames leave exactly the last datagram here
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            command_q <= '0;
        end else if (select_rise) begin
            command_q.write_not_read_bit <= frame_word[DIR_BIT_POS];
            command_q.addr <= frame_word[ADDR_MSB_POS:ADDR_LSB_POS];
            command_q.data <= frame_word[DATA_BITS-1:0];
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            short_q <= 1'b0;
        end else if (select_rise) begin
            short_q <= (frame_count != CNT_FULL);
        end
    end

    // ----------------------------------------------------------------
    // execution sequence
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                // a frame with 1 to 39 clocks is dropped unexecuted; one with no clocks reruns the previous frame if that one had 40
                if (select_rise && frame_count == CNT_FULL) begin
                    state_d = ST_DECODE;
                end
            end
            ST_DECODE: begin
                if (command_q.write_not_read_bit) begin
                    state_d = ST_IDLE;
                end else begin
                    state_d = ST_READ_CAPTURE;
                end
            end
            ST_READ_CAPTURE: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // one-cycle strobes toward the register file
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            write_q <= 1'b0;
            read_q  <= 1'b0;
        end else begin
            write_q <= (state_q == ST_DECODE) && command_q.write_not_read_bit;
            // a read only strobes the address; its data field goes nowhere
            read_q  <= (state_q == ST_DECODE) && !command_q.write_not_read_bit;
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            addr_q  <= '0;
            wdata_q <= DATA_RESET;
        end else if (state_q == ST_DECODE) begin
            addr_q <= command_q.addr;
            if (command_q.write_not_read_bit) begin
                wdata_q <= command_q.data;
            end
        end
    end

    // ----------------------------------------------------------------
    // reply word for the next frame
    // ----------------------------------------------------------------
    always_comb begin
        status_byte = STATUS_RESET;
        status_byte[STAT_RESET_POS] = STATUS_FLAGS_IN.reset_flag;
        status_byte[STAT_DRV1_POS]  = STATUS_FLAGS_IN.drv1_error;
        status_byte[STAT_DRV2_POS]  = STATUS_FLAGS_IN.drv2_error;
    end

    // status is latched when an access ends; data follows the direction
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            reply_q.status <= STATUS_RESET;
        end else if (state_q == ST_DECODE) begin
            reply_q.status <= status_byte;
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            reply_q.data <= DATA_RESET;
        end else if (state_q == ST_DECODE && command_q.write_not_read_bit) begin
            reply_q.data <= command_q.data;
        end else if (state_q == ST_READ_CAPTURE) begin
            // read data arrives right aligned in the strobe cycle, sampled on the edge that ends the strobe
            reply_q.data <= REG_RDATA_IN;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign SDO_OUT             = sdo_q;
    assign SDO_OE_OUT          = sdo_oe_q;
    assign DRIVER_ENABLE_N_OUT = enable_n_q;
    assign REG_WRITE_OUT       = write_q;
    assign REG_READ_OUT        = read_q;
    assign REG_ADDR_OUT        = addr_q;
    assign REG_WDATA_OUT       = wdata_q;
    assign SHORT_FRAME_OUT     = short_q;

endmodule : spi_register_access_slave

`default_nettype wire

// file: verification/spi_register_access_slave_properties.sv
`timescale 1ns/1ns
`default_nettype none

module spi_register_access_slave_properties
    import spi_access_pkg::*;
(
    // clock and reset
    input wire logic                 CLK_IN,
    input wire logic                 RST_IN,
    // link and enable pins
    input wire logic                 CHIP_SELECT_N_IN,
    input wire logic                 SDO_OE_OUT,
    input wire logic                 DRIVER_ENABLE_N_IN,
    input wire logic                 DRIVER_ENABLE_N_OUT,
    // register file side
    input wire logic                 REG_WRITE_OUT,
    input wire logic                 REG_READ_OUT,
    input wire logic [ADDR_BITS-1:0] REG_ADDR_OUT,
    input wire logic [DATA_BITS-1:0] REG_WDATA_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_oe_off;
        CHIP_SELECT_N_IN [*8] |-> !SDO_OE_OUT;
    endproperty
    property p_oe_on;
        !CHIP_SELECT_N_IN [*8] |-> SDO_OE_OUT;
    endproperty
    property p_one_dir;
        !(REG_WRITE_OUT && REG_READ_OUT);
    endproperty
    property p_wr_pulse;
        REG_WRITE_OUT |=> !REG_WRITE_OUT;
    endproperty
    property p_rd_pulse;
        REG_READ_OUT |=> !REG_READ_OUT;
    endproperty
    // a command only runs once the select has been high for a while
    property p_exec_deselected;
        (REG_WRITE_OUT || REG_READ_OUT) |-> CHIP_SELECT_N_IN && $past(CHIP_SELECT_N_IN, 5);
    endproperty
    property p_wdata_hold;
        $changed(REG_WDATA_OUT) |-> REG_WRITE_OUT;
    endproperty
    property p_addr_hold;
        $changed(REG_ADDR_OUT) |-> (REG_WRITE_OUT || REG_READ_OUT);
    endproperty
    property p_enable_low;
        !DRIVER_ENABLE_N_IN [*8] |-> !DRIVER_ENABLE_N_OUT;
    endproperty
    property p_enable_high;
        DRIVER_ENABLE_N_IN [*8] |-> DRIVER_ENABLE_N_OUT;
    endproperty

    a_oe_off: assert property (p_oe_off) else $error("sdo driven while deselected");
    a_oe_on: assert property (p_oe_on) else $error("sdo not driven while selected");
    a_one_dir: assert property (p_one_dir) else $error("read and write strobe together");
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
    a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
    a_exec_deselected: assert property (p_exec_deselected) else $error("strobe in frame");
    a_wdata_hold: assert property (p_wdata_hold) else $error("write data moved");
    a_addr_hold: assert property (p_addr_hold) else $error("address moved");
    a_enable_low: assert property (p_enable_low) else $error("enable not followed");
    a_enable_high: assert property (p_enable_high) else $error("enable not released");

    c_write: cover property (REG_WRITE_OUT);
    c_read: cover property (REG_READ_OUT);
    c_enable: cover property ($fell(DRIVER_ENABLE_N_OUT));
endmodule : spi_register_access_slave_properties

bind spi_register_access_slave spi_register_access_slave_properties
    spi_register_access_slave_properties_i (
    .CLK_IN              (CLK_IN),
    .RST_IN              (RST_IN),
    .CHIP_SELECT_N_IN    (CHIP_SELECT_N_IN),
    .SDO_OE_OUT          (SDO_OE_OUT),
    .DRIVER_ENABLE_N_IN  (DRIVER_ENABLE_N_IN),
    .DRIVER_ENABLE_N_OUT (DRIVER_ENABLE_N_OUT),
    .REG_WRITE_OUT       (REG_WRITE_OUT),
    .REG_READ_OUT        (REG_READ_OUT),
    .REG_ADDR_OUT        (REG_ADDR_OUT),
    .REG_WDATA_OUT       (REG_WDATA_OUT)
);

`default_nettype wire

// file: verification/spi_master_model.sv
`timescale 1ns/1ns
`default_nettype none

module spi_master_model (
    // link pins, seen from the master
    output logic      sck_out,
    output logic      chip_select_n_out,
    output logic      sdi_out,
    input  wire logic sdo_in
);
    logic tick;

    // 6 ns link tick, free of the system clock; bus clock is three ticks per half
    initial begin
        tick = 1'b0;
        sck_out = 1'b1;
        chip_select_n_out = 1'b1;
        sdi_out = 1'b0;
    end
    always #3 tick = ~tick;

    // msb first, change on fall, sample on rise, idle high between frames
    task automatic xfer(input logic [47:0] tx, input int n, output logic [47:0] rx);
        rx = '0;
        @(posedge tick) chip_select_n_out = 1'b0;
        repeat (8) @(posedge tick);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge tick) sck_out = 1'b0;
            sdi_out = tx[i];
            repeat (2) @(posedge tick);
            @(posedge tick) sck_out = 1'b1;
            rx = {rx[46:0], sdo_in};
            repeat (2) @(posedge tick);
        end
        @(posedge tick) chip_select_n_out = 1'b1;
        // released data line shows the inverse so a stale bit cannot pass
        sdi_out = ~sdi_out;
        repeat (20) @(posedge tick);
    endtask : xfer

    task automatic frame(input logic [39:0] tx, output logic [39:0] rx);
        logic [47:0] r;
        xfer({8'h00, tx}, 40, r);
        rx = r[39:0];
    endtask : frame

    // select pulse of 12 ns, below the filter threshold
    task automatic glitch();
        @(posedge tick) chip_select_n_out = 1'b0;
        repeat (2) @(posedge tick);
        chip_select_n_out = 1'b1;
        repeat (20) @(posedge tick);
    endtask : glitch
endmodule : spi_master_model

`default_nettype wire

// file: verification/test_spi_register_access_slave.sv
`timescale 1ns/1ns
`default_nettype none

module test_spi_register_access_slave
    import spi_access_pkg::*;
();
    logic                 clk, rst, sck, chip_select_n, sdi, sdo, sdo_oe, enable_n, enable_n_filt;
    logic                 wr, rd, short_frame;
    logic [ADDR_BITS-1:0] addr;
    logic [DATA_BITS-1:0] wdata, rdata;
    status_flags_t        flags;
    wire                  sdo_line;
    int                   bad_count, check_count, wr_seen, rd_seen, cycles;

    assign sdo_line = (sdo_oe === 1'b1) ? sdo : 1'bz;
    always #4 clk = ~clk;

    spi_register_access_slave spi_register_access_slave_i (
        .CLK_IN(clk), .RST_IN(rst), .SCK_IN(sck), .CHIP_SELECT_N_IN(chip_select_n), .SDI_IN(sdi),
        .SDO_OUT(sdo), .SDO_OE_OUT(sdo_oe), .DRIVER_ENABLE_N_IN(enable_n),
        .DRIVER_ENABLE_N_OUT(enable_n_filt), .REG_WRITE_OUT(wr), .REG_READ_OUT(rd),
        .REG_ADDR_OUT(addr), .REG_WDATA_OUT(wdata), .REG_RDATA_IN(rdata),
        .STATUS_FLAGS_IN(flags), .SHORT_FRAME_OUT(short_frame));
    spi_master_model spi_master_model_i (
        .sck_out(sck), .chip_select_n_out(chip_select_n), .sdi_out(sdi), .sdo_in(sdo_line));

    // ----------------------------------------------------------------
    // register file stand-in and watchdog
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        #1;
        if (rd === 1'b1) rdata = 32'h5A00_0000 | {25'h0, addr};
        if (rd === 1'b1) rd_seen++;
        if (wr === 1'b1) wr_seen++;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            results();
        end
    end

    // ----------------------------------------------------------------
    // helpers and scenarios
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [47:0] exp, input logic [47:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic strobes(input int w, input int r);
        check("write strobes", 48'(w), 48'(wr_seen));
        check("read strobes", 48'(r), 48'(rd_seen));
        wr_seen = 0;
        rd_seen = 0;
    endtask : strobes

    task automatic sc_reset();
        check("oe", 48'h0, 48'(sdo_oe));
        check("enable", 48'h1, 48'(enable_n_filt));
        check("addr", 48'h0, 48'(addr));
        check("wdata", 48'h0, 48'(wdata));
        check("short", 48'h0, 48'(short_frame));
    endtask : sc_reset

    task automatic sc_pipeline();
        logic [39:0] r;
        flags = status_flags_t'(3'b101);
        spi_master_model_i.frame(40'h21_0000_0000, r);
        check("reply after reset", 48'h0, 48'(r));
        strobes(0, 1);
        check("read addr", 48'h21, 48'(addr));
        fork
            spi_master_model_i.frame(40'hA2_00AB_CDEF, r);
            begin
                repeat (100) @(posedge clk);
                #1 flags = status_flags_t'(3'b010);
            end
        join
        check("read reply", 48'h05_5A00_0021, 48'(r));
        strobes(1, 0);
        check("write addr", 48'h22, 48'(addr));
        check("write data", 48'h00AB_CDEF, 48'(wdata));
        @(posedge clk);
        #1 flags = status_flags_t'(3'b111);
        spi_master_model_i.frame(40'h6C_FFFF_FFFF, r);
        check("write echo", 48'h02_00AB_CDEF, 48'(r));
        strobes(0, 1);
        check("kept data", 48'h00AB_CDEF, 48'(wdata));
    endtask : sc_pipeline

    task automatic sc_chain();
        logic [47:0] r;
        spi_master_model_i.xfer({8'h3C, 40'h85_1234_5678}, 48, r);
        check("chained reply", {8'h07, 32'h5A00_006C, 8'h3C}, r);
        strobes(1, 0);
        check("chain addr", 48'h05, 48'(addr));
        check("chain data", 48'h1234_5678, 48'(wdata));
    endtask : sc_chain

    task automatic sc_short();
        logic [47:0] r;
        logic [39:0] q;
        spi_master_model_i.xfer(48'h00_7F_FFFF_FFFF, 39, r);
        strobes(0, 0);
        check("short flag", 48'h1, 48'(short_frame));
        check("short data", 48'h1234_5678, 48'(wdata));
        spi_master_model_i.frame(40'h00_0000_0000, q);
        check("after short", 48'h07_1234_5678, 48'(q));
        strobes(0, 1);
        check("short cleared", 48'h0, 48'(short_frame));
    endtask : sc_short

    task automatic sc_filter();
        spi_master_model_i.glitch();
        strobes(0, 0);
        @(posedge clk);
        #1 enable_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 enable_n = 1'b1;
        repeat (10) @(posedge clk);
        check("enable glitch", 48'h1, 48'(enable_n_filt));
        #1 enable_n = 1'b0;
        repeat (10) @(posedge clk);
        check("enable level", 48'h0, 48'(enable_n_filt));
    endtask : sc_filter

    task automatic results();
        if (bad_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        enable_n = 1'b1;
        rdata = '0;
        flags = '0;
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        repeat (8) @(posedge clk);
        sc_reset();
        sc_pipeline();
        sc_chain();
        sc_short();
        sc_filter();
        results();
    end
endmodule : test_spi_register_access_slave

`default_nettype wire
